// >>> src/arc_pkg.sv
// Constants for the alarm relay controller: register map, fields, timing.
// Assumes a 10 MHz hclk and 32-bit AHB-Lite register access.
package arc_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] ARC_OFS_ALARM  = 8'h00;
  localparam logic [7:0] ARC_OFS_CTRL   = 8'h04;
  localparam logic [7:0] ARC_OFS_STATUS = 8'h08;
  localparam logic [7:0] ARC_OFS_CMD    = 8'h0C;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  // Alarm register
  localparam int ARC_A_NODE_MAJ = 0;
  localparam int ARC_A_NODE_MIN = 1;
  localparam int ARC_A_NET_MAJ  = 2;
  localparam int ARC_A_NET_MIN  = 3;
  // Control register
  localparam int ARC_C_AUX0     = 0;
  localparam int ARC_C_AUX1     = 1;
  localparam int ARC_C_ASSIGNED = 2;
  localparam int ARC_C_TEST_ERR = 3;
  // Command register (write one to act)
  localparam int ARC_K_FAIL_RST = 0;
  localparam int ARC_K_HW_RST   = 1;
  // Status register
  localparam int ARC_S_ACO      = 0;
  localparam int ARC_S_HIST     = 1;
  localparam int ARC_S_FAIL     = 2;
  localparam int ARC_S_ACTIVE   = 3;
  localparam int ARC_S_AUD_ON   = 4;
  localparam int ARC_S_SUPA_BAD = 5;
  localparam int ARC_S_SUPB_BAD = 6;
  localparam int ARC_S_HW_RST   = 7;

  localparam logic [3:0] ARC_ALARM_RST = 4'h0;
  localparam logic [3:0] ARC_CTRL_RST  = 4'h0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int ARC_CLK_HZ       = 10_000_000;
  localparam int ARC_DEBOUNCE_MS  = 10;
  localparam int ARC_DEBOUNCE_CYC = ARC_CLK_HZ / 1000 * ARC_DEBOUNCE_MS;
  localparam int ARC_SELFTEST_MS  = 100;
  localparam int ARC_SELFTEST_CYC = ARC_CLK_HZ / 1000 * ARC_SELFTEST_MS;
  localparam int ARC_HWRST_US     = 10;
  localparam int ARC_HWRST_CYC    = ARC_CLK_HZ / 1_000_000 * ARC_HWRST_US;

endpackage : arc_pkg

// >>> src/arc_top.sv
// Alarm relay controller: alarm commands in over AHB-Lite, relay drives,
// faceplate lamps, supply fail outputs and self-test reporting.
// Assumes buttons and supply ok inputs are asynchronous to hclk.
`timescale 1ns/1ps

module arc_top
  import arc_pkg::*;
#(
  parameter int DEBOUNCE_CYC = ARC_DEBOUNCE_CYC,
  parameter int SELFTEST_CYC = ARC_SELFTEST_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        alarm_cutoff_button,
  input  wire logic        history_clear_button,
  input  wire logic        supply_a_ok,
  input  wire logic        supply_b_ok,
  output logic             supply_a_fail_n,
  output logic             supply_b_fail_n,
  output logic             node_major_visual,
  output logic             node_major_audible,
  output logic             node_minor_visual,
  output logic             node_minor_audible,
  output logic             net_major_drive,
  output logic             net_minor_drive,
  output logic             aux0_drive,
  output logic             aux1_drive,
  output logic             alarm_cutoff_led,
  output logic             history_led,
  output logic             node_major_led,
  output logic             node_minor_led,
  output logic             fail_led,
  output logic             active_led
);

  // ****************************************************************
  // Input synchronisers: three stages, change on 2nd/3rd agreement
  // ****************************************************************
  logic [3:0] sy1_r, sy2_r, sy3_r, in_r;
  wire  [3:0] raw_in = {supply_b_ok, supply_a_ok,
                        history_clear_button, alarm_cutoff_button};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sy1_r <= 4'h0;
      sy2_r <= 4'h0;
      sy3_r <= 4'h0;
      in_r  <= 4'h0;
    end else begin
      sy1_r <= raw_in;
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
      for (int i = 0; i < 4; i++)
        if (sy2_r[i] == sy3_r[i]) in_r[i] <= sy3_r[i];
    end
  end

  // ****************************************************************
  // Button debounce, one pulse per press
  // ****************************************************************
  logic [1:0] btn_press;

  generate
    for (genvar g = 0; g < 2; g++) begin : g_btn
      logic [19:0] cnt_r;
      logic        stab_r;
      logic        prev_r;
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cnt_r  <= 20'h0;
          stab_r <= 1'b0;
          prev_r <= 1'b0;
        end else begin
          prev_r <= stab_r;
          if (in_r[g] == stab_r)
            cnt_r <= 20'h0;
          else if (cnt_r == 20'(DEBOUNCE_CYC - 1)) begin
            cnt_r  <= 20'h0;
            stab_r <= in_r[g];
          end else
            cnt_r <= cnt_r + 20'h1;
        end
      end
      assign btn_press[g]  = stab_r & ~prev_r;
    end
  endgenerate

  wire aco_press  = btn_press[0];
  wire hclr_press = btn_press[1];

  // ****************************************************************
  // AHB-Lite slave, zero wait states
  // ****************************************************************
  logic       dwr_r;
  logic [7:0] dadr_r;
  logic [3:0] alarm_r, ctrl_r;
  logic [7:0] status_w;

  wire take   = hsel & hready & htrans[1];
  wire wr_alm = dwr_r & (dadr_r == ARC_OFS_ALARM);
  wire wr_ctl = dwr_r & (dadr_r == ARC_OFS_CTRL);
  wire wr_cmd = dwr_r & (dadr_r == ARC_OFS_CMD);
  wire [7:0] rd_ofs = {haddr[7:2], 2'b00};
  wire rd_hit = take & ~hwrite;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dwr_r  <= 1'b0;
      dadr_r <= 8'h00;
    end else begin
      dwr_r  <= take & hwrite;
      dadr_r <= rd_ofs;
    end
  end

  logic [31:0] rd_nxt;
  always_comb begin
    case (rd_ofs)
      ARC_OFS_ALARM:  rd_nxt = {28'h0, alarm_r};
      ARC_OFS_CTRL:   rd_nxt = {28'h0, ctrl_r};
      ARC_OFS_STATUS: rd_nxt = {24'h0, status_w};
      default:        rd_nxt = 32'h0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata <= 32'h0;
    else if (rd_hit) hrdata <= rd_nxt;
  end

  // ****************************************************************
  // Hardware reset pause and command registers
  // ****************************************************************
  logic [7:0] hwrst_cnt_r;
  wire        hw_busy = (hwrst_cnt_r != 8'h0);
  wire        hw_req  = wr_cmd & hwdata[ARC_K_HW_RST];
  wire        fl_rst  = wr_cmd & hwdata[ARC_K_FAIL_RST];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hwrst_cnt_r <= 8'h0;
    else if (hw_req) hwrst_cnt_r <= 8'(ARC_HWRST_CYC);
    else if (hw_busy) hwrst_cnt_r <= hwrst_cnt_r - 8'h1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_r <= ARC_ALARM_RST;
      ctrl_r  <= ARC_CTRL_RST;
    end else if (hw_req) begin
      alarm_r <= ARC_ALARM_RST;
      ctrl_r  <= ARC_CTRL_RST;
    end else begin
      if (wr_alm) alarm_r <= hwdata[3:0];
      if (wr_ctl) ctrl_r  <= hwdata[3:0];
    end
  end

  // ****************************************************************
  // Node alarms, cut-off and history
  // ****************************************************************
  wire node_maj = alarm_r[ARC_A_NODE_MAJ] & ~hw_busy;
  wire node_min = alarm_r[ARC_A_NODE_MIN] & ~hw_busy;
  wire node_any = node_maj | node_min;
  wire [1:0] node_vec = {node_min, node_maj};
  logic [1:0] node_prev_r;
  wire new_alarm = |(node_vec & ~node_prev_r);
  logic aco_r, hist_r;

  // cut-off set, cleared by alarm end or new alarm
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aco_r       <= 1'b0;
      node_prev_r <= 2'b00;
    end else begin
      node_prev_r <= node_vec;
      if (!node_any || new_alarm) aco_r <= 1'b0;
      else if (aco_press) aco_r <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hist_r <= 1'b0;
    else if (node_any) hist_r <= 1'b1;
    else if (hclr_press) hist_r <= 1'b0;
  end

  // ****************************************************************
  // Self-test, failure log
  // ****************************************************************
  logic [23:0] st_cnt_r;
  logic        fail_r;
  wire st_tick = (st_cnt_r == 24'(SELFTEST_CYC - 1));
  wire st_bad  = st_tick & ctrl_r[ARC_C_TEST_ERR];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) st_cnt_r <= 24'h0;
    else if (st_tick) st_cnt_r <= 24'h0;
    else st_cnt_r <= st_cnt_r + 24'h1;
  end

  // failure held until reset, set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) fail_r <= 1'b0;
    else if (st_bad) fail_r <= 1'b1;
    else if (fl_rst || hw_req) fail_r <= 1'b0;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  wire aud_on = ~aco_r;
  assign node_major_visual  = ~node_maj;
  assign node_major_audible = ~(node_maj & aud_on);
  assign node_minor_visual  = node_min;
  assign node_minor_audible = node_min & aud_on;
  assign net_major_drive = ~(alarm_r[ARC_A_NET_MAJ] & ~hw_busy);
  assign net_minor_drive = alarm_r[ARC_A_NET_MIN] & ~hw_busy;
  assign aux0_drive = ctrl_r[ARC_C_AUX0] & ~hw_busy;
  assign aux1_drive = ctrl_r[ARC_C_AUX1] & ~hw_busy;
  assign supply_a_fail_n = in_r[2];
  assign supply_b_fail_n = in_r[3];

  assign alarm_cutoff_led = aco_r;
  assign history_led      = hist_r;
  assign node_major_led   = node_maj;
  assign node_minor_led   = node_min;
  assign fail_led   = fail_r;
  assign active_led = ctrl_r[ARC_C_ASSIGNED] & ~fail_r & ~hw_busy;

  always_comb begin
    status_w[ARC_S_ACO]      = aco_r;
    status_w[ARC_S_HIST]     = hist_r;
    status_w[ARC_S_FAIL]     = fail_r;
    status_w[ARC_S_ACTIVE]   = active_led;
    status_w[ARC_S_AUD_ON]   = aud_on & node_any;
    status_w[ARC_S_SUPA_BAD] = ~in_r[2];
    status_w[ARC_S_SUPB_BAD] = ~in_r[3];
    status_w[ARC_S_HW_RST]   = hw_busy;
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_aco_new_alarm: assert property (
    @(posedge hclk) disable iff (!hresetn)
    new_alarm |=> !aco_r)
    else $error("cut-off not cleared by new alarm");

  chk_aco_idle: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !node_any |=> !aco_r)
    else $error("cut-off lamp lit without alarm");

  chk_visual_free: assert property (
    @(posedge hclk) disable iff (!hresetn)
    node_maj |-> !node_major_visual && (node_minor_visual == node_min))
    else $error("visual contact follows cut-off");

  chk_hist_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    node_any |=> hist_r)
    else $error("history not set by alarm");

  chk_history_clear_button: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $fell(hist_r) |-> $past(hclr_press) && !$past(node_any))
    else $error("history cleared illegally");

  chk_fail_sticky: assert property (
    @(posedge hclk) disable iff (!hresetn)
    fail_r && !fl_rst && !hw_req |=> fail_r)
    else $error("failure dropped without reset");

  chk_active_lamp: assert property (
    @(posedge hclk) disable iff (!hresetn)
    active_led |-> ctrl_r[ARC_C_ASSIGNED] && !fail_led)
    else $error("active lamp with failure");

  chk_major_idle: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !alarm_r[ARC_A_NODE_MAJ] && !hw_busy |-> node_major_visual)
    else $error("major relay not energised at idle");

  chk_hw_pause: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hw_req |=> hw_busy [*8])
    else $error("hardware reset pause too short");

endmodule : arc_top

// >>> testbench/arc_ncp_model.sv
// Control processor model: AHB-Lite master, single word transfers.
// Assumes one slave whose hreadyout is looped back as hready.
`timescale 1ns/1ps

module arc_ncp_model (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  logic [31:0] rd_data;
  event        rd_ev;

  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // ****************************************************************
  // One transfer; waits on hready, the bench watchdog bounds it
  // ****************************************************************
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    if (!w) begin
      rd_data = hrdata;
      -> rd_ev;
    end
  endtask : xfer
endmodule : arc_ncp_model

// >>> testbench/arc_top_tb.sv
// Self-checking bench for the alarm relay controller.
// Assumes arc_pkg and arc_top compiled first; short debounce and test.
`timescale 1ns/1ps

module arc_top_tb;
  import arc_pkg::*;
  localparam int STC = 16;
  localparam logic [1:0] SUP [3] = '{2'h1, 2'h2, 2'h3};
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic alarm_cutoff_button, history_clear_button, supply_a_ok, supply_b_ok;
  logic supply_a_fail_n, supply_b_fail_n, node_major_visual;
  logic node_major_audible, node_minor_visual, node_minor_audible;
  logic net_major_drive, net_minor_drive, aux0_drive, aux1_drive;
  logic alarm_cutoff_led, history_led, node_major_led, node_minor_led;
  logic fail_led, active_led;
  wire logic hready = hreadyout;
  wire logic [15:0] pins = {node_major_visual, node_major_audible,
    node_minor_visual, node_minor_audible, net_major_drive,
    net_minor_drive, aux0_drive, aux1_drive, supply_a_fail_n,
    supply_b_fail_n, alarm_cutoff_led, history_led, node_major_led,
    node_minor_led, fail_led, active_led};
  logic [3:0] m_alm;
  logic [1:0] m_aux;
  logic m_asg, m_err, m_aco, m_hist, m_fail, m_sa, m_sb;
  logic [31:0] exq [$];
  event pin_ev;
  int n_fail, checks;

  arc_top #(.DEBOUNCE_CYC(4), .SELFTEST_CYC(STC)) u_arc_top (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .alarm_cutoff_button,
    .history_clear_button, .supply_a_ok, .supply_b_ok, .supply_a_fail_n,
    .supply_b_fail_n, .node_major_visual, .node_major_audible,
    .node_minor_visual, .node_minor_audible, .net_major_drive,
    .net_minor_drive, .aux0_drive, .aux1_drive, .alarm_cutoff_led,
    .history_led, .node_major_led, .node_minor_led, .fail_led,
    .active_led);

  arc_ncp_model u_arc_ncp_model (
    .hclk, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata);

  always #50 hclk = ~hclk;

  // ****************************************************************
  // Expectations and comparison
  // ****************************************************************
  function automatic logic [15:0] exp_pins();
    return {~m_alm[0], ~(m_alm[0] & ~m_aco), m_alm[1], m_alm[1] & ~m_aco,
      ~m_alm[2], m_alm[3], m_aux[0], m_aux[1], m_sa, m_sb, m_aco, m_hist,
      m_alm[0], m_alm[1], m_fail, m_asg & ~m_fail};
  endfunction : exp_pins

  function automatic logic [31:0] exp_st();
    return {24'h0, 1'b0, ~m_sb, ~m_sa, (m_alm[1:0] != 2'h0) & ~m_aco,
      m_asg & ~m_fail, m_fail, m_hist, m_aco};
  endfunction : exp_st

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  always @(u_arc_ncp_model.rd_ev) begin
    check(u_arc_ncp_model.rd_data, exq.pop_front());
    check({31'h0, hresp}, 32'h0);
  end
  always @(pin_ev) check({16'h0, pins}, exq.pop_front());

  // Latched lamps and cut-off settle one edge after the bus write
  task automatic chk_pins();
    @(posedge hclk);
    #1;
    exq.push_back({16'h0, exp_pins()});
    -> pin_ev;
  endtask : chk_pins

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_arc_ncp_model.xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exq.push_back(e);
    u_arc_ncp_model.xfer(1'b0, a, $urandom);
  endtask : rd

  task automatic set_ctrl();
    wr(ARC_OFS_CTRL, {28'h0, m_err, m_asg, m_aux});
  endtask : set_ctrl

  task automatic set_alm(input logic [3:0] v);
    if ((v[1:0] & ~m_alm[1:0]) != 2'h0 || v[1:0] == 2'h0) m_aco = 1'b0;
    if (v[1:0] != 2'h0) m_hist = 1'b1;
    m_alm = v;
    wr(ARC_OFS_ALARM, {28'h0, v});
  endtask : set_alm

  // Long enough for sync plus debounce, released just as long
  task automatic press(input logic hist);
    alarm_cutoff_button <= ~hist;
    history_clear_button <= hist;
    repeat (12) @(posedge hclk);
    alarm_cutoff_button <= 1'b0;
    history_clear_button <= 1'b0;
    repeat (12) @(posedge hclk);
  endtask : press

  task automatic end_of_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (6000) @(posedge hclk);
    n_fail++;
    end_of_test();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    {alarm_cutoff_button, history_clear_button} = 2'h0;
    {supply_a_ok, supply_b_ok} = 2'h3;
    {m_alm, m_aux, m_asg, m_err, m_aco, m_hist, m_fail} = 11'h0;
    {m_sa, m_sb} = 2'h3;
    void'($urandom(32'h1fb8));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (6) @(posedge hclk);
    chk_pins();
    for (int i = 0; i < 16; i++) begin
      m_aux = 2'($urandom);
      set_ctrl();
      set_alm(4'(i));
      chk_pins();
      rd(ARC_OFS_ALARM, {28'h0, m_alm});
      rd(ARC_OFS_STATUS, exp_st());
    end
    set_alm(4'h0);
    chk_pins();
    set_alm(4'h1);
    press(1'b1);
    chk_pins();
    set_alm(4'h0);
    press(1'b1);
    m_hist = 1'b0;
    chk_pins();
    set_alm(4'h1);
    press(1'b0);
    m_aco = 1'b1;
    chk_pins();
    rd(ARC_OFS_STATUS, exp_st());
    set_alm(4'h3);
    chk_pins();
    press(1'b0);
    m_aco = 1'b1;
    set_alm(4'h0);
    chk_pins();
    foreach (SUP[k]) begin
      {supply_a_ok, supply_b_ok} <= SUP[k];
      {m_sa, m_sb} = SUP[k];
      repeat (6) @(posedge hclk);
      chk_pins();
      rd(ARC_OFS_STATUS, exp_st());
    end
    m_asg = 1'b1;
    set_ctrl();
    chk_pins();
    m_err = 1'b1;
    set_ctrl();
    repeat (3 * STC) @(posedge hclk);
    m_fail = 1'b1;
    chk_pins();
    m_err = 1'b0;
    set_ctrl();
    repeat (3 * STC) @(posedge hclk);
    chk_pins();
    wr(ARC_OFS_CMD, 32'h1);
    m_fail = 1'b0;
    repeat (2) @(posedge hclk);
    chk_pins();
    press(1'b1);
    m_hist = 1'b0;
    set_alm(4'hC);
    wr(ARC_OFS_CMD, 32'h2);
    {m_alm, m_aux, m_asg} = 7'h0;
    rd(ARC_OFS_STATUS, exp_st() | (32'h1 << ARC_S_HW_RST));
    repeat (110) @(posedge hclk);
    chk_pins();
    rd(ARC_OFS_CTRL, 32'h0);
    wr(8'h10, $urandom);
    rd(8'h10, 32'h0);
    rd(ARC_OFS_ALARM, 32'h0);
    repeat (4) @(posedge hclk);
    end_of_test();
  end
endmodule : arc_top_tb
